// *** dacis_device.sv ***
`include "dacis_defs.svh"

// Contract
// - Master opens with SDA fall, SCL high
// - Address plus direction, ack on match
// - Direction zero writes, one reads word
// - Upper then lower byte, each acked
// - Load word at lower ack rise
// - Repeated pairs until stop or restart
// - Read sends upper then lower, MSB first
// - Master acks upper, nacks lower byte
// - Master code nacked, then Hs restart
// - Hs persists over restart, stop ends
// - Two-pin address from both selects
// - Single-pin address from low select
// - Broadcast address always acknowledged
// - Address locks on first direct match
// - Top bits zero, mode, twelve data
// - Straight binary data code out
// - Power-up clears word, output zero
// - Nonzero mode bits power down
// - Power-down keeps word, readable
module dacis_device
    import dacis_pkg::*;
#(
    parameter bit TWO_PIN = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Two-wire bus
    dacis_bus_if.device bus,
    // Address select pins
    input wire dacis_tri_e addr_select_high_pin,
    input wire dacis_tri_e addr_select_low_pin,
    output logic addr_sense_en,
    // Converter controls
    output logic [11:0] analog_output,
    output logic powerdown_mode_hi,
    output logic powerdown_mode_lo,
    output logic [2:0] pd_term,
    output logic word_update,
    // Status
    output logic hs_mode,
    output logic addr_locked
);

    // ==================================================
    // State and reset value
    localparam dacis_dev_s RST = '{
        state: DS_IDLE,
        word: `DACIS_WORD_RESET,
        sda_oe_n: 1'b1,
        scl_q: 1'b1,
        sda_q: 1'b1,
        default: '0
    };

    dacis_dev_s r;
    dacis_dev_s n;
    logic [6:0] pin_addr;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic bcast;
    logic hit;
    logic mcode;

    // Termination select for the analog section
    function automatic logic [2:0] term_decode(input logic [1:0] m);
        unique case (m)
            2'h1: term_decode = `DACIS_TERM_MODE1;
            2'h2: term_decode = `DACIS_TERM_MODE2;
            2'h3: term_decode = `DACIS_TERM_MODE3;
            2'h0: term_decode = `DACIS_TERM_NONE;
        endcase
    endfunction

    // ==================================================
    // Address decode
    dacis_addr_decode #(
        .TWO_PIN(TWO_PIN)
    ) u_decode (
        .high_sel(addr_select_high_pin),
        .low_sel(addr_select_low_pin),
        .addr(pin_addr)
    );

    // Bus events from sampled lines
    assign scl_rise = bus.scl & ~r.scl_q;
    assign scl_fall = ~bus.scl & r.scl_q;
    assign start_c = bus.scl & r.scl_q & r.sda_q & ~bus.sda;
    assign stop_c = bus.scl & r.scl_q & ~r.sda_q & bus.sda;
    assign bcast = r.shreg[7:1] == `DACIS_BCAST_ADDR;
    assign hit = bcast ||
        r.shreg[7:1] == (r.locked ? r.addr : pin_addr);
    assign mcode = !r.hs && r.shreg[7:3] == `DACIS_MCODE_TOP;

    // ==================================================
    // Next-state logic
    always_comb begin
        logic [7:0] rd_next;
        rd_next = r.byte_hi ? r.word[7:0] : r.word[15:8];
        n = r;
        n.scl_q = bus.scl;
        n.sda_q = bus.sda;
        n.update = 1'b0;
        if (stop_c) begin
            // Stop leaves Hs and frees the bus
            n.state = DS_IDLE;
            n.hs = 1'b0;
            n.mcode_seen = 1'b0;
            n.sda_oe_n = 1'b1;
        end else if (start_c) begin
            // Start or repeated start awaits an address
            n.state = DS_ADDR;
            n.bitcnt = 4'h0;
            n.sda_oe_n = 1'b1;
            if (r.mcode_seen) begin
                n.hs = 1'b1;
            end
            n.mcode_seen = 1'b0;
        end else begin
            unique case (r.state)
                DS_IDLE: begin
                end
                DS_ADDR, DS_WR: begin
                    if (scl_rise) begin
                        n.shreg = {r.shreg[6:0], bus.sda};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (scl_fall && r.bitcnt == 4'h8) begin
                        if (r.state == DS_WR) begin
                            n.sda_oe_n = 1'b0;
                            n.state = DS_ACK_W;
                            if (r.byte_hi) begin
                                n.upper = r.shreg;
                            end
                        end else if (mcode) begin
                            n.mcode_seen = 1'b1;
                            n.state = DS_IDLE;
                        end else if (hit) begin
                            n.sda_oe_n = 1'b0;
                            n.rw = r.shreg[0];
                            n.state = DS_ACK_A;
                            if (!bcast && !r.locked) begin
                                n.locked = 1'b1;
                                n.addr = pin_addr;
                            end
                        end else begin
                            n.state = DS_IDLE;
                        end
                    end
                end
                DS_ACK_A: begin
                    if (scl_fall) begin
                        n.bitcnt = 4'h0;
                        n.byte_hi = 1'b1;
                        if (r.rw) begin
                            // Read returns the stored word, top bits zero
                            n.shreg = r.word[15:8];
                            n.sda_oe_n = r.word[15];
                            n.state = DS_RD;
                        end else begin
                            n.sda_oe_n = 1'b1;
                            n.state = DS_WR;
                        end
                    end
                end
                DS_ACK_W: begin
                    if (scl_rise && !r.byte_hi) begin
                        // Whole word applied, top bits forced zero
                        n.word = {2'h0, r.upper[5:0], r.shreg};
                        n.pd_term = term_decode(r.upper[5:4]);
                        n.update = 1'b1;
                    end
                    if (scl_fall) begin
                        n.sda_oe_n = 1'b1;
                        n.bitcnt = 4'h0;
                        n.byte_hi = ~r.byte_hi;
                        n.state = DS_WR;
                    end
                end
                DS_RD: begin
                    if (scl_rise) begin
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (r.bitcnt == 4'h8) begin
                            n.sda_oe_n = 1'b1;
                            n.state = DS_ACK_R;
                        end else begin
                            n.shreg = {r.shreg[6:0], 1'b0};
                            n.sda_oe_n = r.shreg[6];
                        end
                    end
                end
                DS_ACK_R: begin
                    if (scl_rise) begin
                        n.mack = ~bus.sda;
                    end else if (scl_fall) begin
                        if (r.mack) begin
                            // Master wants another byte
                            n.byte_hi = ~r.byte_hi;
                            n.shreg = rd_next;
                            n.sda_oe_n = rd_next[7];
                            n.bitcnt = 4'h0;
                            n.state = DS_RD;
                        end else begin
                            n.state = DS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ==================================================
    // State register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    // ==================================================
    // Outputs
    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe_n = r.sda_oe_n;
    assign addr_sense_en = ~r.locked;
    assign analog_output = r.word[11:0];
    assign powerdown_mode_hi = r.word[13];
    assign powerdown_mode_lo = r.word[12];
    assign pd_term = r.pd_term;
    assign word_update = r.update;
    assign hs_mode = r.hs;
    assign addr_locked = r.locked;
endmodule

// *** dacis_defs.svh ***
`ifndef DACIS_DEFS_SVH
`define DACIS_DEFS_SVH

// ==================================================
// Addresses
`define DACIS_BCAST_ADDR 7'h48
`define DACIS_MCODE_TOP 5'h01
`define DACIS_MCODE_BYTE 8'h08
`define DACIS_HI_FLOAT 5'h03
`define DACIS_HI_GND 5'h02
`define DACIS_HI_SUPPLY 5'h13
`define DACIS_LO_FLOAT 2'h0
`define DACIS_LO_GND 2'h1
`define DACIS_LO_SUPPLY 2'h2

// ==================================================
// Tri-level pin sense codes
`define DACIS_TRI_FLOAT 2'h0
`define DACIS_TRI_GND 2'h1
`define DACIS_TRI_SUPPLY 2'h2

// ==================================================
// Conversion word layout and reset
`define DACIS_WORD_RESET 16'h0000
`define DACIS_PD_NORMAL 2'h0
`define DACIS_TERM_NONE 3'h0
`define DACIS_TERM_MODE1 3'h1
`define DACIS_TERM_MODE2 3'h2
`define DACIS_TERM_MODE3 3'h4

// ==================================================
// Timing
`define DACIS_REF_CLK_MHZ 25
`define DACIS_SF_QTR_NS 2500
`define DACIS_HS_QTR_NS 74
`define DACIS_SF_QTR_CYC \
    ((`DACIS_SF_QTR_NS * `DACIS_REF_CLK_MHZ + 999) / 1000)
`define DACIS_HS_QTR_CYC \
    ((`DACIS_HS_QTR_NS * `DACIS_REF_CLK_MHZ + 999) / 1000)

`endif

// *** dacis_pkg.sv ***
`include "dacis_defs.svh"

package dacis_pkg;

    // ==================================================
    // Pin sense and state codes
    typedef enum logic [1:0] {
        DACIS_FLOAT = `DACIS_TRI_FLOAT,
        DACIS_GND = `DACIS_TRI_GND,
        DACIS_SUPPLY = `DACIS_TRI_SUPPLY
    } dacis_tri_e;

    typedef enum logic [6:0] {
        DS_IDLE = 7'h01,
        DS_ADDR = 7'h02,
        DS_ACK_A = 7'h04,
        DS_WR = 7'h08,
        DS_ACK_W = 7'h10,
        DS_RD = 7'h20,
        DS_ACK_R = 7'h40
    } dacis_dev_state_e;

    typedef enum logic [4:0] {
        MS_IDLE = 5'h01,
        MS_START = 5'h02,
        MS_BYTE = 5'h04,
        MS_RSTART = 5'h08,
        MS_STOP = 5'h10
    } dacis_mst_state_e;

    // ==================================================
    // State records
    typedef struct packed {
        dacis_dev_state_e state;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] upper;
        logic byte_hi;
        logic rw;
        logic mack;
        logic [15:0] word;
        logic [2:0] pd_term;
        logic locked;
        logic [6:0] addr;
        logic hs;
        logic mcode_seen;
        logic sda_oe_n;
        logic scl_q;
        logic sda_q;
        logic update;
    } dacis_dev_s;

    typedef struct packed {
        dacis_mst_state_e state;
        logic [1:0] q;
        logic [7:0] cnt;
        logic [3:0] bitn;
        logic [1:0] seq;
        logic [7:0] shreg;
        logic [6:0] addr;
        logic hs;
        logic read;
        logic rxnack;
        logic [15:0] wword;
        logic [15:0] rword;
        logic scl_oe_n;
        logic sda_oe_n;
        logic busy;
        logic done;
        logic nacked;
    } dacis_mst_s;

endpackage

// *** dacis_bus_if.sv ***
// ==================================================
// Open-drain two-wire bus with pull-ups
interface dacis_bus_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl;
    logic sda;

    // Wired-AND of all drivers, high when released
    assign scl = m_scl_oe_n | m_scl_o;
    assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

    modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n,
                    input scl, sda);
    modport device (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface

// *** dacis_addr_decode.sv ***
`include "dacis_defs.svh"

// ==================================================
// Slave address from tri-level select pins
module dacis_addr_decode
    import dacis_pkg::*;
#(
    parameter bit TWO_PIN = 1'b1
) (
    // Pin senses
    input wire dacis_tri_e high_sel,
    input wire dacis_tri_e low_sel,
    // Decoded address
    output logic [6:0] addr
);

    // Upper five address bits
    function automatic logic [4:0] hi_field(input dacis_tri_e s);
        unique case (s)
            DACIS_GND: hi_field = `DACIS_HI_GND;
            DACIS_SUPPLY: hi_field = `DACIS_HI_SUPPLY;
            default: hi_field = `DACIS_HI_FLOAT;
        endcase
    endfunction

    // Lower two address bits
    function automatic logic [1:0] lo_field(input dacis_tri_e s);
        unique case (s)
            DACIS_GND: lo_field = `DACIS_LO_GND;
            DACIS_SUPPLY: lo_field = `DACIS_LO_SUPPLY;
            default: lo_field = `DACIS_LO_FLOAT;
        endcase
    endfunction

    // Single-pin variant sees the high pin as floating
    assign addr = {TWO_PIN ? hi_field(high_sel) : `DACIS_HI_FLOAT,
                   lo_field(low_sel)};
endmodule

// *** dacis_master.sv ***
`include "dacis_defs.svh"

// ==================================================
// Bus master: one word per request
module dacis_master
    import dacis_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Two-wire bus
    dacis_bus_if.master bus,
    // Request
    input wire logic req,
    input wire logic [6:0] req_addr,
    input wire logic req_read,
    input wire logic req_hs,
    input wire logic [15:0] req_word,
    // Answer
    output logic busy,
    output logic done,
    output logic nacked,
    output logic [15:0] rd_word
);

    localparam logic [7:0] SF_RELOAD = 8'(`DACIS_SF_QTR_CYC - 1);
    localparam logic [7:0] HS_RELOAD = 8'(`DACIS_HS_QTR_CYC - 1);
    localparam dacis_mst_s RST = '{
        state: MS_IDLE,
        scl_oe_n: 1'b1,
        sda_oe_n: 1'b1,
        default: '0
    };

    dacis_mst_s r;
    dacis_mst_s n;
    logic tick;
    logic ack_bit;

    assign tick = r.cnt == 8'h00;
    // Acks upper read byte, nacks lower, releases on writes
    assign ack_bit = !(r.read && r.seq == 2'h2);

    // ==================================================
    // Quarter-bit sequencer
    always_comb begin
        n = r;
        n.done = 1'b0;
        if (r.state != MS_IDLE) begin
            n.cnt = tick ? (r.hs ? HS_RELOAD : SF_RELOAD) : r.cnt - 8'h01;
            if (tick) begin
                n.q = r.q + 2'h1;
            end
        end
        unique case (r.state)
            MS_IDLE: begin
                if (req) begin
                    n.busy = 1'b1;
                    n.nacked = 1'b0;
                    n.read = req_read;
                    n.addr = req_addr;
                    n.wword = req_word;
                    n.hs = 1'b0;
                    n.q = 2'h0;
                    n.cnt = SF_RELOAD;
                    n.state = MS_START;
                    n.seq = req_hs ? 2'h0 : 2'h1;
                    n.shreg = req_hs ? `DACIS_MCODE_BYTE
                                     : {req_addr, req_read};
                end
            end
            MS_START: begin
                if (tick && r.q == 2'h1) begin
                    n.sda_oe_n = 1'b0;
                end else if (tick && r.q == 2'h2) begin
                    n.scl_oe_n = 1'b0;
                    n.q = 2'h0;
                    n.bitn = 4'h0;
                    n.state = MS_BYTE;
                end
            end
            MS_BYTE: begin
                if (tick) begin
                    unique case (r.q)
                        2'h0: n.sda_oe_n = (r.bitn == 4'h8) ? ack_bit
                                                           : r.shreg[7];
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: begin
                            if (r.bitn == 4'h8) begin
                                n.rxnack = bus.sda;
                            end else begin
                                n.shreg = {r.shreg[6:0], bus.sda};
                            end
                        end
                        2'h3: begin
                            n.scl_oe_n = 1'b0;
                            n.bitn = r.bitn + 4'h1;
                            if (r.bitn == 4'h8) begin
                                n.bitn = 4'h0;
                                unique case (r.seq)
                                    2'h0: begin
                                        n.hs = 1'b1;
                                        n.seq = 2'h1;
                                        n.shreg = {r.addr, r.read};
                                        n.state = MS_RSTART;
                                    end
                                    2'h1: begin
                                        n.seq = 2'h2;
                                        n.shreg = r.read ? 8'hff
                                                         : r.wword[15:8];
                                        if (r.rxnack) begin
                                            n.nacked = 1'b1;
                                            n.state = MS_STOP;
                                        end
                                    end
                                    2'h2: begin
                                        n.seq = 2'h3;
                                        n.shreg = r.read ? 8'hff
                                                         : r.wword[7:0];
                                        if (r.read) begin
                                            n.rword[15:8] = r.shreg;
                                        end else if (r.rxnack) begin
                                            n.nacked = 1'b1;
                                            n.state = MS_STOP;
                                        end
                                    end
                                    2'h3: begin
                                        if (r.read) begin
                                            n.rword[7:0] = r.shreg;
                                        end else if (r.rxnack) begin
                                            n.nacked = 1'b1;
                                        end
                                        n.state = MS_STOP;
                                    end
                                endcase
                            end
                        end
                    endcase
                end
            end
            MS_RSTART: begin
                if (tick) begin
                    unique case (r.q)
                        2'h0: n.sda_oe_n = 1'b1;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b0;
                        2'h3: begin
                            n.scl_oe_n = 1'b0;
                            n.state = MS_BYTE;
                        end
                    endcase
                end
            end
            MS_STOP: begin
                if (tick) begin
                    unique case (r.q)
                        2'h0: n.sda_oe_n = 1'b0;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b1;
                        2'h3: begin
                            n.state = MS_IDLE;
                            n.hs = 1'b0;
                            n.busy = 1'b0;
                            n.done = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    // ==================================================
    // State register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    // ==================================================
    // Outputs
    assign bus.m_scl_o = 1'b0;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_scl_oe_n = r.scl_oe_n;
    assign bus.m_sda_oe_n = r.sda_oe_n;
    assign busy = r.busy;
    assign done = r.done;
    assign nacked = r.nacked;
    assign rd_word = r.rword;
endmodule

// *** dacis_assertions.sv ***
// ==================================================
// Protocol checker beside the shared bus
module dacis_assertions
    import dacis_pkg::*;
(
    // Clock, reset and bus wires
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_oe_n,
    // Device outputs
    input wire logic [11:0] analog_output,
    input wire logic powerdown_mode_hi,
    input wire logic powerdown_mode_lo,
    input wire logic [2:0] pd_term,
    input wire logic word_update,
    input wire logic hs_mode,
    input wire logic addr_sense_en,
    input wire logic addr_locked
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Device moves SDA only while SCL is low
    property p_sda_moves; $changed(s_sda_oe_n) |-> !scl; endproperty
    a_sda_moves: assert property (p_sda_moves)
        else $error("device moved sda while scl high");
    // Update is a single pulse taken while SCL is high
    property p_upd_pulse; word_update |=> !word_update; endproperty
    a_upd_pulse: assert property (p_upd_pulse)
        else $error("word update longer than one cycle");
    property p_upd_scl; word_update |-> $past(scl); endproperty
    a_upd_scl: assert property (p_upd_scl)
        else $error("word update outside scl high");
    // Analog output and termination change only with an update
    property p_upd_cause;
        $changed(analog_output) || $changed(pd_term) |-> word_update;
    endproperty
    a_upd_cause: assert property (p_upd_cause)
        else $error("output changed without update");
    // Mode bits decode to termination
    property p_pd_map;
        ({powerdown_mode_hi, powerdown_mode_lo} == 2'h0) ? pd_term == 3'h0
        : pd_term == (3'h1 << ({powerdown_mode_hi, powerdown_mode_lo} - 2'h1));
    endproperty
    a_pd_map: assert property (p_pd_map)
        else $error("termination does not match mode bits");
    // Locked address stops pin sensing and stays locked
    property p_lock_sense; addr_locked |-> !addr_sense_en; endproperty
    a_lock_sense: assert property (p_lock_sense)
        else $error("pins sensed after lock");
    property p_lock_hold; addr_locked |=> addr_locked; endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("address lock dropped");
    // Lock is taken only on an acknowledged address
    property p_lock_ack; $rose(addr_locked) |-> !s_sda_oe_n; endproperty
    a_lock_ack: assert property (p_lock_ack)
        else $error("address locked without acknowledge");
    // High-speed mode begins only at a start condition
    property p_hs_start; $rose(hs_mode) |-> scl && !sda; endproperty
    a_hs_start: assert property (p_hs_start)
        else $error("high speed mode entered outside a start");
    // Stop leaves high-speed mode
    property p_stop_hs; scl && $rose(sda) |-> ##[1:3] !hs_mode; endproperty
    a_stop_hs: assert property (p_stop_hs)
        else $error("high speed mode kept after stop");

    // Main scenarios reached
    c_hs_update: cover property (word_update && hs_mode);
    c_lock: cover property ($rose(addr_locked));
    c_pd3: cover property (word_update && pd_term == 3'h4);
endmodule

// *** dac_i2c_slave_register_tb.sv ***
// ==================================================
// Master and device joined on one bus
module dac_i2c_slave_register_tb
    import dacis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic nk; logic rd; logic [15:0] w;} dacis_note_s;
    logic ref_clk = 1'b0, reset = 1'b1, req = 1'b0, req_read = 1'b0;
    logic req_hs = 1'b0, busy, done, nacked, addr_sense_en, word_update;
    logic hs_mode, addr_locked, powerdown_mode_hi, powerdown_mode_lo;
    logic [6:0] req_addr = 7'h00;
    logic [15:0] req_word = 16'h0000, rd_word, cur = 16'h0000;
    logic [2:0] pd_term;
    logic [11:0] analog_output;
    logic [31:0] lfsr_st = 32'h5d0a;
    dacis_tri_e hi_pin = DACIS_FLOAT, lo_pin = DACIS_FLOAT;
    int miscompares = 0, tests_run = 0, cycles = 0;
    dacis_note_s notes[$];
    dacis_note_s mon_n;
    dacis_bus_if bus();

    dacis_master dacis_master_i (.ref_clk(ref_clk), .reset(reset), .bus(bus),
        .req(req), .req_addr(req_addr), .req_read(req_read), .req_hs(req_hs),
        .req_word(req_word), .busy(busy), .done(done), .nacked(nacked),
        .rd_word(rd_word));
    dacis_device dacis_device_i (.ref_clk(ref_clk), .reset(reset), .bus(bus),
        .addr_select_high_pin(hi_pin), .addr_select_low_pin(lo_pin),
        .addr_sense_en(addr_sense_en), .analog_output(analog_output),
        .powerdown_mode_hi(powerdown_mode_hi),
        .powerdown_mode_lo(powerdown_mode_lo), .pd_term(pd_term),
        .word_update(word_update), .hs_mode(hs_mode),
        .addr_locked(addr_locked));
    dacis_assertions dacis_assertions_i (.ref_clk(ref_clk), .reset(reset),
        .scl(bus.scl), .sda(bus.sda), .s_sda_oe_n(bus.s_sda_oe_n),
        .analog_output(analog_output), .powerdown_mode_hi(powerdown_mode_hi),
        .powerdown_mode_lo(powerdown_mode_lo), .pd_term(pd_term),
        .word_update(word_update), .hs_mode(hs_mode),
        .addr_sense_en(addr_sense_en), .addr_locked(addr_locked));

    // ==================================================
    // Helpers
    always #20 ref_clk = ~ref_clk;

    function automatic logic [15:0] rnd();
        lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1]};
        return lfsr_st[15:0];
    endfunction

    task automatic check(input string name, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One request; expectation noted first
    task automatic xfer(input logic [6:0] a, input logic rd, hs, nk,
                        input logic [15:0] w);
        notes.push_back('{nk, rd, rd ? cur : {2'b00, w[13:0]}});
        if (!rd && !nk) cur = {2'b00, w[13:0]};
        @(posedge ref_clk);
        req <= 1'b1;
        req_addr <= a;
        req_read <= rd;
        req_hs <= hs;
        req_word <= w;
        @(posedge ref_clk);
        req <= 1'b0;
        @(posedge ref_clk);
        check("busy", 16'h0001, 16'(busy));
        while (done !== 1'b1) @(posedge ref_clk);
    endtask

    // ==================================================
    // Result watcher
    always @(posedge ref_clk) begin
        if (done === 1'b1) begin
            mon_n = notes.pop_front();
            check("nacked", 16'(mon_n.nk), 16'(nacked));
            check("hs_mode", 16'h0000, 16'(hs_mode));
            if (mon_n.rd && !mon_n.nk) check("word", mon_n.w, rd_word);
            if (!mon_n.rd && !mon_n.nk) begin
                check("analog", 16'(mon_n.w[11:0]), 16'(analog_output));
                check("pd_bits", 16'(mon_n.w[13:12]),
                    16'({powerdown_mode_hi, powerdown_mode_lo}));
            end
        end
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ==================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        check("analog", 16'h0000, 16'(analog_output));
        xfer(7'h48, 1'b0, 1'b0, 1'b0, 16'hc000 | rnd());
        check("addr_locked", 16'h0000, 16'(addr_locked));
        xfer(7'h0d, 1'b0, 1'b0, 1'b1, rnd());
        for (int m = 0; m < 4; m++) begin
            xfer(7'h0c, 1'b0, 1'b1, 1'b0,
                16'hc000 | (16'(m) << 12) | (rnd() & 16'h0fff));
        end
        check("addr_locked", 16'h0001, 16'(addr_locked));
        hi_pin <= DACIS_GND;
        lo_pin <= DACIS_GND;
        xfer(7'h09, 1'b0, 1'b1, 1'b1, rnd());
        xfer(7'h0c, 1'b1, 1'b1, 1'b0, 16'h0000);
        reset <= 1'b1;
        cur = 16'h0000;
        hi_pin <= DACIS_SUPPLY;
        lo_pin <= DACIS_SUPPLY;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        check("addr_locked", 16'h0000, 16'(addr_locked));
        check("analog", 16'h0000, 16'(analog_output));
        xfer(7'h4e, 1'b1, 1'b0, 1'b0, 16'h0000);
        @(posedge ref_clk);
        tally_and_finish();
    end
endmodule
